// ### rtl/rsra_pkg.sv
// Package for the program sequencer and data memory addressing block.
// Assumes one instruction-cycle clock and an active-low asynchronous reset.
package rsra_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int ROM_WORDS = 512;
  localparam int PC_W = 9;
  localparam int PAGE_COUNT = 8;
  localparam int PAGE_WORDS = 64;
  localparam int PAGE_OFF_W = 6;
  localparam int DIGIT_W = 4;
  localparam int RAM_REGS = 4;
  localparam int RAM_DIGITS = 8;
  localparam int RAM_ADDR_W = 5;
  localparam int RAM_WORDS = 32;

  // ----------------------------------------------------------------------
  // Reset values and fixed addresses
  // ----------------------------------------------------------------------
  localparam logic [8:0] PC_RESET = 9'h000;
  localparam logic [1:0] BR_RESET = 2'h0;
  localparam logic [3:0] BD_RESET = 4'h0;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [1:0] DIRECT_REG = 2'h3;
  localparam logic [3:0] DIRECT_DIGIT = 4'hf;
  localparam logic [3:0] BD_MAX = 4'hf;
  localparam logic [3:0] BD_MIN = 4'h0;

  // ----------------------------------------------------------------------
  // Sequencer operations
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    RSRA_SEQ_NEXT = 3'b000,
    RSRA_SEQ_JUMP = 3'b001,
    RSRA_SEQ_PAGE_JUMP = 3'b010,
    RSRA_SEQ_CALL = 3'b011,
    RSRA_SEQ_RETURN = 3'b100,
    RSRA_SEQ_INDIRECT = 3'b101
  } rsra_seq_t;

  // Data memory operations.
  typedef enum logic [2:0] {
    RSRA_MEM_NONE = 3'b000,
    RSRA_MEM_LOAD = 3'b001,
    RSRA_MEM_STORE = 3'b010,
    RSRA_MEM_EXCH = 3'b011,
    RSRA_MEM_XINC = 3'b100,
    RSRA_MEM_XDEC = 3'b101,
    RSRA_MEM_XDIRECT = 3'b110,
    RSRA_MEM_SETB = 3'b111
  } rsra_mem_t;

  // Data source for a RAM write.
  typedef enum logic [1:0] {
    RSRA_SRC_ACC = 2'b00,
    RSRA_SRC_PORT_LO = 2'b01,
    RSRA_SRC_PORT_HI = 2'b10
  } rsra_src_t;

endpackage

// ### rtl/rsra_ram.sv
// Digit memory: 32 words of 4 bits, registered read data.
// Assumes a single clock; contents are never cleared by reset.
`timescale 1ns/1ps
module rsra_ram
  import rsra_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [4:0] addr,
  input wire logic [3:0] wr_data,
  output logic [3:0] rd_data
);

  logic [3:0] mem [RAM_WORDS];

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Read data reflect the old word so an exchange sees the prior value.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end

endmodule

// ### rtl/rsra_top.sv
// Program sequencer with two-level return stack and digit memory addressing.
// Assumes the instruction decoder drives seq_op, mem_op and operands for one
// cycle per instruction, and that the program store is outside this block.
// Notes on behaviour
// - A 9-bit counter addresses one of 512 eight-bit program words.
// - Page jumps see 8 pages of 64; indirect jumps keep bit 8 and load 8 bits.
// - Counter loads every cycle; plain instructions advance it by one.
// - Two 9-bit return slots form a last-in first-out stack.
// - Data memory holds 4 registers of 8 four-bit digits, 128 bits.
// - Six-bit pointer: top 2 bits pick register, low 3 digit bits pick digit.
// - Digit field top bit is ignored, so two values reach each digit.
// - Digit field drives the four general-purpose digit outputs.
// - Exchange-step skip is true on 0/15 wrap, never on 7/8.
// - Selected digit loads, stores, exchanges, copies out or takes port data.
// - Exchange-direct reaches register 3 digit 15 without the pointer.
// - Reset clears the program counter to address 0.
// - Reset leaves data memory contents untouched.
`timescale 1ns/1ps
module rsra_top
  import rsra_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire rsra_seq_t seq_op,
  input wire logic [8:0] jump_target,
  input wire logic [5:0] page_offset,
  input wire logic [7:0] rom_data,
  input wire rsra_mem_t mem_op,
  input wire rsra_src_t mem_src,
  input wire logic [3:0] acc_in,
  input wire logic [7:0] port_in,
  input wire logic [5:0] pointer_in,
  output logic [8:0] instruction_pointer,
  output logic [8:0] return_slot_one,
  output logic [8:0] return_slot_two,
  output logic [1:0] ram_register_select,
  output logic [3:0] ram_digit_select,
  output logic [3:0] digit_out,
  output logic [3:0] mem_digit,
  output logic skip_next
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Physical digit address; the digit field's top bit is dropped.
  function automatic logic [4:0] ram_addr(input logic [1:0] r, input logic [3:0] d);
    ram_addr = {r, d[2:0]};
  endfunction

  // ----------------------------------------------------------------------
  // Program sequencer
  // ----------------------------------------------------------------------
  logic [8:0] pc_reg, pc_next;
  logic [8:0] sa_reg, sa_next;
  logic [8:0] sb_reg, sb_next;
  logic [8:0] pc_inc;

  // Next address and stack movement for each control transfer.
  always_comb begin
    pc_inc = pc_reg + 9'h001;
    pc_next = pc_inc;
    sa_next = sa_reg;
    sb_next = sb_reg;
    unique case (seq_op)
      RSRA_SEQ_NEXT: begin
        pc_next = pc_inc;
      end
      RSRA_SEQ_JUMP: begin
        pc_next = jump_target;
      end
      RSRA_SEQ_PAGE_JUMP: begin
        pc_next = {pc_reg[8:6], page_offset};
      end
      RSRA_SEQ_CALL: begin
        pc_next = jump_target;
        sa_next = pc_inc;
        sb_next = sa_reg;
      end
      RSRA_SEQ_RETURN: begin
        pc_next = sa_reg;
        sa_next = sb_reg;
      end
      RSRA_SEQ_INDIRECT: begin
        pc_next = {pc_reg[8:8], rom_data};
      end
      default: begin
        pc_next = pc_inc;
      end
    endcase
  end

  // Sequencer registers; the counter restarts at address 0.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_reg <= PC_RESET;
      sa_reg <= PC_RESET;
      sb_reg <= PC_RESET;
    end else begin
      pc_reg <= pc_next;
      sa_reg <= sa_next;
      sb_reg <= sb_next;
    end
  end

  assign instruction_pointer = pc_reg;
  assign return_slot_one = sa_reg;
  assign return_slot_two = sb_reg;

  // ----------------------------------------------------------------------
  // Data memory pointer
  // ----------------------------------------------------------------------
  logic [1:0] br_reg, br_next;
  logic [3:0] bd_reg, bd_next;
  logic skip_reg, skip_next_c;
  logic [3:0] bd_step;
  logic [4:0] ram_sel;
  logic ram_we;
  logic [3:0] ram_wdata;
  logic [3:0] ram_rdata;
  logic [7:0] port_meta_reg;
  logic [7:0] port_sync_reg;

  // Port pins arrive from outside the clock's domain, so they pass two flip-flops.
  // Only the second stage feeds the RAM write path; port data lag two cycles.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_meta_reg <= PORT_RESET;
      port_sync_reg <= PORT_RESET;
    end else begin
      port_meta_reg <= port_in;
      port_sync_reg <= port_meta_reg;
    end
  end

  // Pointer update, skip decision and RAM write selection.
  always_comb begin
    br_next = br_reg;
    bd_next = bd_reg;
    skip_next_c = 1'b0;
    bd_step = bd_reg;
    ram_sel = ram_addr(br_reg, bd_reg);
    ram_we = 1'b0;
    ram_wdata = acc_in;
    unique case (mem_src)
      RSRA_SRC_ACC: ram_wdata = acc_in;
      RSRA_SRC_PORT_LO: ram_wdata = port_sync_reg[3:0];
      RSRA_SRC_PORT_HI: ram_wdata = port_sync_reg[7:4];
      default: ram_wdata = acc_in;
    endcase
    unique case (mem_op)
      RSRA_MEM_NONE: begin
        ram_we = 1'b0;
      end
      RSRA_MEM_LOAD: begin
        ram_we = 1'b0;
      end
      RSRA_MEM_STORE: begin
        ram_we = 1'b1;
      end
      RSRA_MEM_EXCH: begin
        ram_we = 1'b1;
      end
      RSRA_MEM_XINC: begin
        ram_we = 1'b1;
        bd_step = bd_reg + 4'h1;
        bd_next = bd_step;
        skip_next_c = (bd_reg == BD_MAX);
      end
      RSRA_MEM_XDEC: begin
        ram_we = 1'b1;
        bd_step = bd_reg - 4'h1;
        bd_next = bd_step;
        skip_next_c = (bd_reg == BD_MIN);
      end
      RSRA_MEM_XDIRECT: begin
        ram_we = 1'b1;
        ram_sel = ram_addr(DIRECT_REG, DIRECT_DIGIT);
      end
      RSRA_MEM_SETB: begin
        br_next = pointer_in[5:4];
        bd_next = pointer_in[3:0];
      end
    endcase
  end

  // Pointer registers; memory itself keeps its contents across reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      br_reg <= BR_RESET;
      bd_reg <= BD_RESET;
      skip_reg <= 1'b0;
    end else begin
      br_reg <= br_next;
      bd_reg <= bd_next;
      skip_reg <= skip_next_c;
    end
  end

  // Thirty-two digit store, 4 registers by 8 digits.
  rsra_ram u_ram (
    .clk(clk),
    .wr_en(ram_we),
    .addr(ram_sel),
    .wr_data(ram_wdata),
    .rd_data(ram_rdata)
  );

  assign ram_register_select = br_reg;
  assign ram_digit_select = bd_reg;
  assign digit_out = bd_reg;
  assign mem_digit = ram_rdata;
  assign skip_next = skip_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_call;
    seq_op == RSRA_SEQ_CALL;
  endsequence

  sequence s_ret;
    seq_op == RSRA_SEQ_RETURN;
  endsequence

  a_pc_increment: assert property (@(posedge clk) disable iff (!rstn)
    seq_op == RSRA_SEQ_NEXT |=> pc_reg == $past(pc_reg) + 9'h001)
    else $error("counter did not advance by one");

  a_page_jump_keeps: assert property (@(posedge clk) disable iff (!rstn)
    seq_op == RSRA_SEQ_PAGE_JUMP |=> pc_reg[8:6] == $past(pc_reg[8:6])
      && pc_reg[5:0] == $past(page_offset))
    else $error("page jump left its page");

  a_call_push: assert property (@(posedge clk) disable iff (!rstn)
    s_call |=> sa_reg == $past(pc_reg) + 9'h001 && sb_reg == $past(sa_reg))
    else $error("call push wrong");

  a_call_return: assert property (@(posedge clk) disable iff (!rstn)
    s_call ##1 s_ret |=> pc_reg == $past(pc_reg, 2) + 9'h001)
    else $error("return missed the call site");

  a_jump_target: assert property (@(posedge clk) disable iff (!rstn)
    seq_op == RSRA_SEQ_JUMP |=> pc_reg == $past(jump_target))
    else $error("jump address not taken");

  a_skip_wrap: assert property (@(posedge clk) disable iff (!rstn)
    (mem_op == RSRA_MEM_XINC || mem_op == RSRA_MEM_XDEC) |=>
      skip_reg == ($past(bd_reg) == ($past(mem_op) == RSRA_MEM_XINC ? BD_MAX : BD_MIN)))
    else $error("skip on wrong digit step");

  a_digit_alias: assert property (@(posedge clk) disable iff (!rstn)
    mem_op == RSRA_MEM_STORE |-> ram_sel == {br_reg, bd_reg[2:0]})
    else $error("digit select used top bit");

  a_direct_addr: assert property (@(posedge clk) disable iff (!rstn)
    mem_op == RSRA_MEM_XDIRECT |-> ram_sel == 5'h1f && ram_we)
    else $error("direct exchange missed register 3 digit 15");

  a_pointer_load: assert property (@(posedge clk) disable iff (!rstn)
    mem_op == RSRA_MEM_SETB |=> {br_reg, bd_reg} == $past(pointer_in)
      && digit_out == $past(pointer_in[3:0]))
    else $error("pointer load wrong");

endmodule

// ### dv/tb_top.sv
// Self-checking bench for the sequencer and digit memory addressing block.
// Assumes rsra_pkg and the design files are compiled first.
`timescale 1ns/1ps
module tb_top;
  import rsra_pkg::*;
  logic clk;
  logic rstn;
  rsra_seq_t seq_op;
  rsra_mem_t mem_op;
  rsra_src_t mem_src;
  logic [8:0] jump_target;
  logic [5:0] page_offset;
  logic [5:0] pointer_in;
  logic [7:0] rom_data;
  logic [7:0] port_in;
  logic [3:0] acc_in;
  logic [8:0] ip, s1, s2, e_pc, e_s1, e_s2;
  logic [1:0] br, e_br;
  logic [3:0] bd, dout, mdig, e_bd, e_md;
  logic skip, e_sk, md_ok;
  logic [7:0] p1, p2;
  logic [3:0] ram [32];
  logic [31:0] lfsr;
  int n_errors, num_checks, cyc;

  // ------------------------------------------------------------
  // Clock, design and run limit
  // ------------------------------------------------------------
  // The clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 clk = ~clk;

  rsra_top rsra_top_inst (.clk(clk), .rstn(rstn), .seq_op(seq_op),
    .jump_target(jump_target), .page_offset(page_offset), .rom_data(rom_data),
    .mem_op(mem_op), .mem_src(mem_src), .acc_in(acc_in), .port_in(port_in),
    .pointer_in(pointer_in), .instruction_pointer(ip), .return_slot_one(s1),
    .return_slot_two(s2), .ram_register_select(br), .ram_digit_select(bd),
    .digit_out(dout), .mem_digit(mdig), .skip_next(skip));

  // A hang is cut off long after the planned traffic has finished.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Next pseudo-random value.
  function automatic logic [31:0] nxt(logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
  endfunction

  // Compares a program address.
  task automatic chk_addr(logic [8:0] got, logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a digit-sized value.
  task automatic chk_dig(logic [3:0] got, logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Mirrors one clock edge of the block in the bench's own state.
  task automatic model_step();
    logic [4:0] a;
    logic [3:0] src;
    a = (mem_op == RSRA_MEM_XDIRECT) ? {DIRECT_REG, DIRECT_DIGIT[2:0]} : {e_br, e_bd[2:0]};
    src = (mem_src == RSRA_SRC_ACC) ? acc_in :
          (mem_src == RSRA_SRC_PORT_LO) ? p2[3:0] : p2[7:4];
    md_ok = (mem_op != RSRA_MEM_NONE) && (mem_op != RSRA_MEM_SETB);
    e_md = ram[a];
    if (md_ok && mem_op != RSRA_MEM_LOAD) ram[a] = src;
    e_sk = (mem_op == RSRA_MEM_XINC && e_bd == BD_MAX) ||
           (mem_op == RSRA_MEM_XDEC && e_bd == BD_MIN);
    if (mem_op == RSRA_MEM_XINC) e_bd = e_bd + 4'h1;
    if (mem_op == RSRA_MEM_XDEC) e_bd = e_bd - 4'h1;
    if (mem_op == RSRA_MEM_SETB) {e_br, e_bd} = pointer_in;
    case (seq_op)
      RSRA_SEQ_JUMP: e_pc = jump_target;
      RSRA_SEQ_PAGE_JUMP: e_pc = {e_pc[8:6], page_offset};
      RSRA_SEQ_CALL: begin
        e_s2 = e_s1;
        e_s1 = e_pc + 9'h001;
        e_pc = jump_target;
      end
      RSRA_SEQ_RETURN: begin
        e_pc = e_s1;
        e_s1 = e_s2;
      end
      RSRA_SEQ_INDIRECT: e_pc = {e_pc[8], rom_data};
      default: e_pc = e_pc + 9'h001;
    endcase
    // Port data reach the memory two edges after they are sampled.
    p2 = p1;
    p1 = port_in;
  endtask

  // Passes one edge, then compares every output with the mirror; mem_digit only on memory accesses with a known expected word.
  task automatic step();
    @(posedge clk);
    model_step();
    #2;
    chk_addr(ip, e_pc);
    chk_addr(s1, e_s1);
    chk_addr(s2, e_s2);
    chk_dig({2'h0, br}, {2'h0, e_br});
    chk_dig(bd, e_bd);
    chk_dig(dout, e_bd);
    chk_dig({3'h0, skip}, {3'h0, e_sk});
    if (md_ok && ^e_md !== 1'bx) chk_dig(mdig, e_md);
  endtask

  // Sets the two operations and runs one cycle.
  task automatic go(rsra_seq_t s, rsra_mem_t m);
    seq_op = s;
    mem_op = m;
    step();
  endtask

  // Holds reset for n cycles; memory contents are kept.
  task automatic do_reset(int n);
    rstn = 1'b0;
    seq_op = RSRA_SEQ_NEXT;
    mem_op = RSRA_MEM_NONE;
    {e_pc, e_s1, e_s2, e_br, e_bd, e_sk, p1, p2} = '0;
    repeat (n) @(posedge clk);
    #2;
    chk_addr(ip, 9'h000);
    chk_addr(s1, 9'h000);
    chk_dig(bd, 4'h0);
    rstn = 1'b1;
  endtask

  // Draws fresh random values for every input.
  task automatic rnd();
    lfsr = nxt(lfsr);
    seq_op = rsra_seq_t'(lfsr[2:0] % 6);
    mem_op = rsra_mem_t'(lfsr[5:3]);
    mem_src = rsra_src_t'(lfsr[7:6] % 3);
    jump_target = lfsr[16:8];
    page_offset = lfsr[22:17];
    pointer_in = lfsr[28:23];
    lfsr = nxt(lfsr);
    rom_data = lfsr[7:0];
    port_in = lfsr[15:8];
    acc_in = lfsr[19:16];
  endtask

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  // Corner cases first, then random traffic with a reset in the middle.
  initial begin
    clk = 0;
    cyc = 0;
    n_errors = 0;
    num_checks = 0;
    lfsr = 32'h0000_99c9;
    rnd();
    mem_src = RSRA_SRC_ACC;
    do_reset(20);
    pointer_in = 6'h3f;
    acc_in = 4'h5;
    go(RSRA_SEQ_NEXT, RSRA_MEM_SETB);
    go(RSRA_SEQ_NEXT, RSRA_MEM_XINC);
    go(RSRA_SEQ_NEXT, RSRA_MEM_XDEC);
    pointer_in = 6'h37;
    go(RSRA_SEQ_NEXT, RSRA_MEM_SETB);
    go(RSRA_SEQ_NEXT, RSRA_MEM_XINC);
    acc_in = 4'ha;
    port_in = 8'hc3;
    go(RSRA_SEQ_NEXT, RSRA_MEM_STORE);
    go(RSRA_SEQ_NEXT, RSRA_MEM_XDEC);
    pointer_in = 6'h30;
    go(RSRA_SEQ_NEXT, RSRA_MEM_SETB);
    go(RSRA_SEQ_NEXT, RSRA_MEM_LOAD);
    mem_src = RSRA_SRC_PORT_HI;
    go(RSRA_SEQ_NEXT, RSRA_MEM_XDIRECT);
    pointer_in = 6'h3f;
    go(RSRA_SEQ_NEXT, RSRA_MEM_SETB);
    go(RSRA_SEQ_NEXT, RSRA_MEM_EXCH);
    jump_target = 9'h1c5;
    go(RSRA_SEQ_CALL, RSRA_MEM_NONE);
    jump_target = 9'h0a2;
    go(RSRA_SEQ_CALL, RSRA_MEM_NONE);
    go(RSRA_SEQ_RETURN, RSRA_MEM_NONE);
    go(RSRA_SEQ_RETURN, RSRA_MEM_NONE);
    page_offset = 6'h3f;
    go(RSRA_SEQ_PAGE_JUMP, RSRA_MEM_NONE);
    go(RSRA_SEQ_NEXT, RSRA_MEM_NONE);
    rom_data = 8'h80;
    go(RSRA_SEQ_INDIRECT, RSRA_MEM_NONE);
    for (int i = 0; i < 3000; i++) begin
      if (i == 1500) do_reset(3);
      rnd();
      step();
    end
    test_done();
  end
endmodule
